// File: beat_fifo.sv
`timescale 1ns/1ps
module beat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic push;
  logic pop;

  // Full counts only the array; output register is extra slack
  assign in_ready = count_ff < (AW+1)'(DEPTH);
  assign push = in_valid && in_ready;
  assign pop = (count_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  // Storage has no reset; pointers, count and output register do
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read side
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule // beat_fifo

// File: burst_ctrl_pkg.sv
package burst_ctrl_pkg;

  // Burst length selection codes
  localparam logic [1:0] BL_SEL_4 = 2'h0;
  localparam logic [1:0] BL_SEL_8 = 2'h1;
  localparam logic [1:0] BL_SEL_16 = 2'h2;

  // Clocks per burst (two beats per clock)
  localparam logic [3:0] HALF_BL_4 = 4'h2;
  localparam logic [3:0] HALF_BL_8 = 4'h4;
  localparam logic [3:0] HALF_BL_16 = 4'h8;

  // Minimum column-to-column delay in clocks
  localparam logic [3:0] CCD_CLKS = 4'h2;

  // Latency pipeline depth (largest read latency)
  localparam int LAT_DEPTH = 8;

  // Command/address bit positions, rising half
  localparam int CA_BIT0 = 0;
  localparam int CA_BIT1 = 1;
  localparam int CA_BIT2 = 2;
  localparam int CA_BIT3 = 3;
  localparam int CA_AB_BIT = 4;
  localparam int CA_BA_LO = 7;
  localparam int CA_BA_HI = 9;
  localparam int CA_COLR_LO = 5;
  localparam int CA_COLR_HI = 6;
  // Falling half
  localparam int CA_AP_BIT = 0;
  localparam int CA_COLF_LO = 1;
  localparam int CA_COLF_HI = 9;

  localparam int COL_W = 11;
  localparam int BANKS = 8;
  localparam int FIFO_DEPTH = 8;

  // Reset values
  localparam logic [7:0] PIPE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [4:0] EFF_LEN_RST = 5'h00;

  // One command/address sample: both halves of a clock
  typedef struct packed {
    logic cs_n;
    logic [9:0] rise;
    logic [9:0] fall;
  } ca_t;

  // One clock of write data: two beats and their masks
  typedef struct packed {
    logic [15:0] d_rise;
    logic [15:0] d_fall;
    logic [1:0] m_rise;
    logic [1:0] m_fall;
  } dq_beat_t;

  // One stored word toward the array; mask high inhibits a byte
  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [31:0] data;
    logic [3:0] mask;
  } wr_word_t;

  // Precharge request to the bank logic
  typedef struct packed {
    logic valid;
    logic all;
    logic [BANKS-1:0] bank_mask;
  } pre_req_t;

endpackage

// File: burst_engine.sv
`timescale 1ns/1ps
module burst_engine
  import burst_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire ca_t ca_in,
  input wire logic [1:0] bl_sel,
  input wire logic [3:0] read_latency,
  input wire logic [3:0] write_latency,
  input wire dq_beat_t dq_in,
  input wire logic [31:0] rd_array_data,
  output logic [COL_W-1:0] rd_array_col,
  output logic [31:0] dq_out,
  output logic dq_oe_n,
  output wr_word_t wr_word,
  output logic wr_valid,
  input wire logic wr_ready,
  output pre_req_t pre_req,
  output logic [4:0] eff_len,
  output logic protocol_err,
  output logic overrun
);

  // Command decode, sampled on the rising edge
  logic cmd_sel;
  logic is_rw;
  logic is_rd;
  logic is_wr;
  logic is_bst;
  logic is_pre;
  logic is_other;
  logic [COL_W-1:0] cmd_col;
  logic [3:0] half_bl;

  assign cmd_sel = !ca_in.cs_n;
  assign is_rw = cmd_sel && ca_in.rise[CA_BIT0] && !ca_in.rise[CA_BIT1];
  assign is_rd = is_rw && ca_in.rise[CA_BIT2];
  assign is_wr = is_rw && !ca_in.rise[CA_BIT2];
  assign is_bst = cmd_sel && ca_in.rise[CA_BIT0] && ca_in.rise[CA_BIT1]
    && !ca_in.rise[CA_BIT2] && !ca_in.rise[CA_BIT3];
  assign is_pre = cmd_sel && ca_in.rise[CA_BIT0] && ca_in.rise[CA_BIT1]
    && !ca_in.rise[CA_BIT2] && ca_in.rise[CA_BIT3];
  // Anything else that is selected: activate, refresh, mode register
  assign is_other = cmd_sel && !is_rw && !is_bst && !is_pre;
  assign cmd_col = {ca_in.fall[CA_COLF_HI:CA_COLF_LO], ca_in.rise[CA_COLR_HI:CA_COLR_LO]};

  // Burst length in clocks
  always_comb begin
    unique case (bl_sel)
      BL_SEL_8: half_bl = HALF_BL_8;
      BL_SEL_16: half_bl = HALF_BL_16;
      default: half_bl = HALF_BL_4;
    endcase
  end

  // Age of the most recent read or write, in clocks
  logic [3:0] age_ff;
  logic last_wr_ff;
  logic last_ap_ff;
  logic live_ff;
  logic bst_used_ff;
  logic [3:0] age_next;
  logic burst_live;
  logic age_even;
  logic age_ccd;

  assign age_next = age_ff + 4'h1;
  assign burst_live = live_ff && (age_next < half_bl);
  assign age_even = !age_next[0];
  assign age_ccd = age_next >= CCD_CLKS;

  // Tracks the latest access so a terminate knows what it cuts
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_ff <= CNT_RST;
      last_wr_ff <= 1'b0;
      last_ap_ff <= 1'b0;
      live_ff <= 1'b0;
      bst_used_ff <= 1'b0;
    end else if (is_rw) begin
      age_ff <= CNT_RST;
      last_wr_ff <= is_wr;
      last_ap_ff <= ca_in.fall[CA_AP_BIT];
      live_ff <= 1'b1;
      bst_used_ff <= 1'b0;
    end else begin
      if (age_ff != HALF_BL_16) begin
        age_ff <= age_next;
      end
      if (!burst_live) begin
        live_ff <= 1'b0;
      end
      if (is_bst && burst_live) begin
        live_ff <= 1'b0;
        bst_used_ff <= 1'b1;
      end
    end
  end

  // Misuse by the controller is flagged, never acted on silently
  logic err_next;
  always_comb begin
    err_next = 1'b0;
    if (live_ff && burst_live && !last_wr_ff) begin
      if (is_wr || is_pre || is_other) begin
        err_next = 1'b1;
      end
      if (is_rd && (!age_even || !age_ccd)) begin
        err_next = 1'b1;
      end
    end
    if (live_ff && burst_live && last_wr_ff) begin
      if (is_rd || is_pre || is_other) begin
        err_next = 1'b1;
      end
      if (is_wr && (!age_even || !age_ccd)) begin
        err_next = 1'b1;
      end
      if (is_wr && half_bl == HALF_BL_4) begin
        err_next = 1'b1;
      end
      if ((is_wr || is_bst) && last_ap_ff) begin
        err_next = 1'b1;
      end
    end
    if (is_bst && (!burst_live || bst_used_ff)) begin
      err_next = 1'b1;
    end
    if (is_bst && burst_live && !age_even) begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      protocol_err <= 1'b0;
    end else begin
      protocol_err <= err_next;
    end
  end

  // Effective length of the latest burst, full or cut, in beats
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      eff_len <= EFF_LEN_RST;
    end else if ((is_rw || is_bst) && burst_live) begin
      eff_len <= {age_next, 1'b0};
    end else if (is_rw) begin
      eff_len <= {half_bl, 1'b0};
    end
  end

  // Latency pipelines: start and stop marks with the column alongside
  logic [LAT_DEPTH-1:0] rd_start_ff;
  logic [LAT_DEPTH-1:0] rd_stop_ff;
  logic [LAT_DEPTH-1:0] wr_start_ff;
  logic [LAT_DEPTH-1:0] wr_stop_ff;
  logic [COL_W-1:0] rd_col_pipe_ff [LAT_DEPTH];
  logic [COL_W-1:0] wr_col_pipe_ff [LAT_DEPTH];
  logic [2:0] rd_slot;
  logic [2:0] wr_slot;
  logic bst_rd;
  logic bst_wr;

  // A zero latency setting is treated as one clock
  assign rd_slot = (read_latency == 4'h0) ? 3'h0 : 3'(read_latency - 4'h1);
  assign wr_slot = (write_latency == 4'h0) ? 3'h0 : 3'(write_latency - 4'h1);
  assign bst_rd = is_bst && burst_live && !last_wr_ff && !bst_used_ff;
  assign bst_wr = is_bst && burst_live && last_wr_ff && !bst_used_ff && !last_ap_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_start_ff <= PIPE_RST;
      rd_stop_ff <= PIPE_RST;
      wr_start_ff <= PIPE_RST;
      wr_stop_ff <= PIPE_RST;
    end else begin
      rd_start_ff <= (rd_start_ff >> 1) | (LAT_DEPTH'(is_rd) << rd_slot);
      rd_stop_ff <= (rd_stop_ff >> 1) | (LAT_DEPTH'(bst_rd) << rd_slot);
      wr_start_ff <= (wr_start_ff >> 1) | (LAT_DEPTH'(is_wr) << wr_slot);
      wr_stop_ff <= (wr_stop_ff >> 1) | (LAT_DEPTH'(bst_wr) << wr_slot);
    end
  end

  // Column pipelines need no reset; only the marks are trusted
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LAT_DEPTH; i++) begin
      if (is_rd && rd_slot == 3'(i)) begin
        rd_col_pipe_ff[i] <= cmd_col;
      end else if (i < LAT_DEPTH - 1) begin
        rd_col_pipe_ff[i] <= rd_col_pipe_ff[i+1];
      end
      if (is_wr && wr_slot == 3'(i)) begin
        wr_col_pipe_ff[i] <= cmd_col;
      end else if (i < LAT_DEPTH - 1) begin
        wr_col_pipe_ff[i] <= wr_col_pipe_ff[i+1];
      end
    end
  end

  // Data-phase burst counters; a newer start simply reloads them
  logic [3:0] rd_cnt_ff;
  logic [3:0] wr_cnt_ff;
  logic [COL_W-1:0] rd_col_ff;
  logic [COL_W-1:0] wr_col_ff;
  logic rd_phase;
  logic wr_phase;

  assign rd_phase = rd_cnt_ff != CNT_RST;
  assign wr_phase = wr_cnt_ff != CNT_RST;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_cnt_ff <= CNT_RST;
      rd_col_ff <= '0;
    end else if (rd_start_ff[0]) begin
      rd_cnt_ff <= half_bl;
      rd_col_ff <= rd_col_pipe_ff[0];
    end else if (rd_stop_ff[0]) begin
      rd_cnt_ff <= CNT_RST;
    end else if (rd_phase) begin
      rd_cnt_ff <= rd_cnt_ff - 4'h1;
      rd_col_ff <= rd_col_ff + COL_W'(2);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_cnt_ff <= CNT_RST;
      wr_col_ff <= '0;
    end else if (wr_start_ff[0]) begin
      wr_cnt_ff <= half_bl;
      wr_col_ff <= wr_col_pipe_ff[0];
    end else if (wr_stop_ff[0]) begin
      wr_cnt_ff <= CNT_RST;
    end else if (wr_phase) begin
      wr_cnt_ff <= wr_cnt_ff - 4'h1;
      wr_col_ff <= wr_col_ff + COL_W'(2);
    end
  end

  // Read data out: array is addressed one clock ahead of the pins
  assign rd_array_col = rd_col_ff;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dq_out <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      dq_out <= rd_phase ? rd_array_data : '0;
      dq_oe_n <= !rd_phase;
    end
  end

  // Write capture: both beats and their byte masks go in together
  wr_word_t cap_word;
  logic cap_ready;
  assign cap_word.col = wr_col_ff;
  assign cap_word.data = {dq_in.d_fall, dq_in.d_rise};
  assign cap_word.mask = {dq_in.m_fall, dq_in.m_rise};

  // The DRAM side cannot stall, so a full buffer loses the word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      overrun <= 1'b0;
    end else begin
      overrun <= wr_phase && !cap_ready;
    end
  end

  beat_fifo #(
    .WIDTH($bits(wr_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(wr_phase),
    .in_ready(cap_ready),
    .in_data(cap_word),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_word)
  );

  // Precharge: one bank or all, reported for one clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_req <= '0;
    end else begin
      pre_req.valid <= is_pre;
      pre_req.all <= is_pre && ca_in.rise[CA_AB_BIT];
      if (!is_pre) begin
        pre_req.bank_mask <= '0;
      end else if (ca_in.rise[CA_AB_BIT]) begin
        pre_req.bank_mask <= '1;
      end else begin
        pre_req.bank_mask <= BANKS'(1) << ca_in.rise[CA_BA_HI:CA_BA_LO];
      end
    end
  end

endmodule // burst_engine

// File: burst_engine_props.sv
`timescale 1ns/1ps
module burst_engine_props
  import burst_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire ca_t ca_in,
  input wire logic [1:0] bl_sel,
  input wire logic [3:0] read_latency,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe_n,
  input wire wr_word_t wr_word,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire pre_req_t pre_req,
  input wire logic [4:0] eff_len,
  input wire logic protocol_err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic pre_cmd, acc_cmd, rd_cmd, wr_cmd;
  logic bst_cmd;
  logic cut_now;
  logic [4:0] cut_beats;
  logic [3:0] acc_age_ff;
  logic acc_live_ff;
  logic [3:0] lat;
  logic [4:0] blen;
  logic [9:0] rd_hist_ff;
  // Command decode of this edge
  assign pre_cmd = !ca_in.cs_n && ca_in.rise[3:0] == 4'hB;
  assign acc_cmd = !ca_in.cs_n && ca_in.rise[1:0] == 2'h1;
  assign rd_cmd = acc_cmd && ca_in.rise[2];
  assign wr_cmd = acc_cmd && !ca_in.rise[2];
  assign lat = (read_latency == 4'h0) ? 4'h1 : read_latency;
  assign blen = (bl_sel == BL_SEL_8) ? 5'h08 : (bl_sel == BL_SEL_16) ? 5'h10 : 5'h04;
  assign bst_cmd = !ca_in.cs_n && ca_in.rise[3:0] == 4'h3;
  // Latest access still inside its burst, judged from the bus alone
  assign cut_now = acc_live_ff && ((acc_age_ff + 4'h1) < blen[4:1]);
  assign cut_beats = {acc_age_ff + 4'h1, 1'b0};
  // Age of the latest access; a terminate or the burst's end retires it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_age_ff <= 4'h0;
      acc_live_ff <= 1'b0;
    end else if (acc_cmd) begin
      acc_age_ff <= 4'h0;
      acc_live_ff <= 1'b1;
    end else begin
      if (acc_age_ff != 4'hF) begin
        acc_age_ff <= acc_age_ff + 4'h1;
      end
      if (!cut_now || bst_cmd) begin
        acc_live_ff <= 1'b0;
      end
    end
  end
  // Read history, so a run-time latency needs no variable delay
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_hist_ff <= 10'h000;
    end else begin
      rd_hist_ff <= {rd_hist_ff[8:0], rd_cmd};
    end
  end
  a_pre_decode: assert property (pre_cmd |=> pre_req.valid)
    else $error("precharge not answered");
  a_pre_quiet: assert property (!pre_cmd |=> !pre_req.valid)
    else $error("precharge without command");
  a_pre_all: assert property (pre_cmd && ca_in.rise[4] |=> pre_req.all)
    else $error("all-bank flag lost");
  a_pre_bank: assert property (pre_cmd && !ca_in.rise[4] |=>
    !pre_req.all && pre_req.bank_mask == (8'h01 << $past(ca_in.rise[9:7])))
    else $error("wrong bank precharged");
  a_rd_latency: assert property (rd_hist_ff[lat + 4'h1] |-> !dq_oe_n)
    else $error("read data late");
  a_eff_len: assert property (acc_cmd && !cut_now |=> eff_len == blen)
    else $error("burst length wrong");
  a_cut_len: assert property ((acc_cmd || bst_cmd) && cut_now |=>
    eff_len == $past(cut_beats))
    else $error("cut length wrong");
  a_oe_idle: assert property (dq_oe_n |-> dq_out == 32'h0)
    else $error("data while idle");
  a_err_quiet: assert property (ca_in.cs_n |=> !protocol_err)
    else $error("error without command");
  a_wr_bound: assert property (wr_cmd |-> ##[2:40] wr_valid)
    else $error("write word never offered");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("word changed while stalled");
endmodule // burst_engine_props

bind burst_engine burst_engine_props u_props (.core_clk, .reset_n, .ca_in, .bl_sel,
  .read_latency, .dq_out, .dq_oe_n, .wr_word, .wr_valid, .wr_ready, .pre_req, .eff_len,
  .protocol_err);

// File: ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model
  import burst_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic [3:0] wl,
  input wire logic [3:0] half,
  output ca_t ca_in,
  output dq_beat_t dq_in
);
  dq_beat_t beats[$];
  int starts[$];
  int cyc = 0;
  int left = 0;
  initial begin
    ca_in = '{cs_n: 1'b1, rise: 10'h3FF, fall: 10'h3FF};
    dq_in = '0;
  end
  // One command a call; deselected bus shows inverted leftovers, not the old value
  task automatic send(input ca_t c);
    @(posedge core_clk);
    if (c.rise[2:0] == 3'h1) begin
      starts.push_back(cyc + 1 + int'(wl));
    end
    ca_in <= c;
    @(posedge core_clk);
    ca_in <= '{cs_n: 1'b1, rise: ~c.rise, fall: ~c.fall};
  endtask
  // Two commands on consecutive clocks, to reach odd interrupt ages
  task automatic send_pair(input ca_t c1, input ca_t c2);
    @(posedge core_clk);
    if (c1.rise[2:0] == 3'h1) begin
      starts.push_back(cyc + 1 + int'(wl));
    end
    ca_in <= c1;
    @(posedge core_clk);
    if (c2.rise[2:0] == 3'h1) begin
      starts.push_back(cyc + 1 + int'(wl));
    end
    ca_in <= c2;
    @(posedge core_clk);
    ca_in <= '{cs_n: 1'b1, rise: ~c2.rise, fall: ~c2.fall};
  endtask
  // Write data from WL clocks on for BL/2 clocks; toggling junk outside bursts
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (starts.size() > 0 && starts[0] == cyc) begin
      void'(starts.pop_front());
      left = int'(half);
    end
    if (left > 0) begin
      left = left - 1;
      dq_in <= (beats.size() > 0) ? beats.pop_front() : ~dq_in;
    end else begin
      dq_in <= ~dq_in;
    end
  end
endmodule // ctrl_model

// File: tb.sv
`timescale 1ns/1ps
module tb
  import burst_ctrl_pkg::*;
;
  localparam logic [3:0] OP_RD = 4'h5;
  localparam logic [3:0] OP_WR = 4'h1;
  localparam logic [3:0] OP_BST = 4'h3;
  localparam logic [3:0] OP_PRE = 4'hB;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] bl_sel = BL_SEL_4;
  logic [3:0] read_latency = 4'h3;
  logic [3:0] write_latency = 4'h1;
  logic wr_ready = 1'b1;
  logic ovr_seen = 1'b0;
  logic [3:0] half;
  ca_t ca_in;
  dq_beat_t dq_in;
  logic [COL_W-1:0] rd_array_col;
  logic [31:0] rd_array_data, dq_out;
  logic dq_oe_n, wr_valid, protocol_err, overrun;
  wr_word_t wr_word, exp_q[$];
  pre_req_t pre_req;
  logic [4:0] eff_len;
  int errors = 0;
  int total_checks = 0;
  // Precharge rows: {all flag, bank, expected bank mask}
  logic [11:0] rows [9] = '{12'h001, 12'h102, 12'h204, 12'h308, 12'h410, 12'h520,
    12'h640, 12'h780, 12'hAFF};
  // Array content is a function of the column, so read data can be predicted
  assign rd_array_data = {rd_array_col, 10'h000, rd_array_col};
  assign half = (bl_sel == BL_SEL_8) ? HALF_BL_8 : (bl_sel == BL_SEL_16) ? HALF_BL_16 : HALF_BL_4;
  burst_engine dut (.core_clk, .reset_n, .ca_in, .bl_sel, .read_latency, .write_latency,
    .dq_in, .rd_array_data, .rd_array_col, .dq_out, .dq_oe_n, .wr_word, .wr_valid,
    .wr_ready, .pre_req, .eff_len, .protocol_err, .overrun);
  ctrl_model host (.core_clk, .wl(write_latency), .half, .ca_in, .dq_in);
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // Overrun is registered, high on the clock after each lost word, so latch it
  always @(posedge core_clk) begin
    if (overrun === 1'b1) ovr_seen <= 1'b1;
  end
  function automatic ca_t mk(input logic [3:0] op, input logic [10:0] col, input logic ap,
    input logic ab, input logic [2:0] ba);
    mk = '{cs_n: 1'b0, rise: {ba, col[1:0], ab, op}, fall: {col[10:2], ap}};
  endfunction
  function automatic logic [32:0] beat(input logic [10:0] col);
    beat = {1'b0, col, 10'h000, col};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic final_report;
    $display("errors=%0d total_checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [46:0] got, input logic [46:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Waits for a word, compares it, then pops it with a one-cycle ready
  task automatic pop_word;
    int n;
    n = 0;
    while (wr_valid !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    if (n == 40) begin
      chk(47'h0, 47'h1, "wait timeout");
      final_report();
    end else begin
      chk(wr_word, exp_q.pop_front(), "word");
      @(posedge core_clk) wr_ready <= 1'b1;
      @(posedge core_clk) wr_ready <= 1'b0;
      #1;
    end
  endtask
  initial begin
    dq_in_b: begin
    end
  end
  initial begin
    dq_beat_t b;
    int k;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    tick(1);
    chk(47'({dq_oe_n, pre_req, wr_valid, protocol_err, eff_len}), 47'h20000, "reset");
    host.send(mk(OP_BST, 11'h000, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "idle terminate");
    // No activate ever follows these precharges
    foreach (rows[i]) begin
      host.send(mk(OP_PRE, 11'h000, 1'b0, rows[i][11], rows[i][10:8]));
      tick(0);
      chk(47'(pre_req), 47'({1'b1, rows[i][11], rows[i][7:0]}), "precharge");
    end
    // Plain read, BL4
    host.send(mk(OP_RD, 11'h010, 1'b0, 1'b0, 3'h0));
    tick(4);
    chk(47'({dq_oe_n, dq_out}), 47'(beat(11'h010)), "read beat");
    tick(1);
    chk(47'({dq_oe_n, dq_out}), 47'(beat(11'h012)), "read beat");
    tick(1);
    chk(47'(dq_oe_n), 47'h1, "read end");
    // Precharge BL/2 clocks after a BL4 read is legal
    host.send(mk(OP_RD, 11'h030, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_PRE, 11'h000, 1'b0, 1'b0, 3'h5));
    tick(0);
    chk(47'({pre_req, protocol_err}), 47'({1'b1, 1'b0, 8'h20, 1'b0}), "read to pre");
    tick(4);
    // BL8 read cut by read at an even age
    @(posedge core_clk) bl_sel <= BL_SEL_8;
    host.send(mk(OP_RD, 11'h020, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_RD, 11'h080, 1'b0, 1'b0, 3'h0));
    tick(3);
    chk(47'({dq_oe_n, dq_out}), 47'(beat(11'h022)), "first read");
    tick(1);
    chk(47'({dq_oe_n, dq_out}), 47'(beat(11'h080)), "second read");
    tick(10);
    // BL16 read terminated at age 2, then a second terminate
    @(posedge core_clk) bl_sel <= BL_SEL_16;
    host.send(mk(OP_RD, 11'h100, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_BST, 11'h000, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_BST, 11'h000, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "second terminate");
    chk(47'(eff_len), 47'h4, "cut length");
    tick(2);
    chk(47'(dq_oe_n), 47'h1, "cut stop");
    tick(12);
    // Read cut by a write is flagged
    @(posedge core_clk) bl_sel <= BL_SEL_8;
    host.send(mk(OP_RD, 11'h140, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_WR, 11'h180, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "read cut by write");
    tick(12);
    // Write cut by a read is flagged
    host.send(mk(OP_WR, 11'h1C0, 1'b0, 1'b0, 3'h0));
    host.send(mk(OP_RD, 11'h0C0, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "write cut by read");
    tick(12);
    // BL4 write cut one clock later is flagged
    @(posedge core_clk) bl_sel <= BL_SEL_4;
    host.send_pair(mk(OP_WR, 11'h000, 1'b0, 1'b0, 3'h0),
      mk(OP_WR, 11'h008, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "BL4 write cut");
    tick(10);
    @(posedge core_clk) bl_sel <= BL_SEL_8;
    // Write with auto-precharge cannot be terminated
    host.send(mk(OP_WR, 11'h200, 1'b1, 1'b0, 3'h0));
    host.send(mk(OP_BST, 11'h000, 1'b0, 1'b0, 3'h0));
    tick(0);
    chk(47'(protocol_err), 47'h1, "terminate of auto-precharge write");
    tick(20);
    chk(47'(wr_valid), 47'h0, "queue empty");
    // Gapless masked writes against a stalled sink until words are lost
    @(posedge core_clk) bl_sel <= BL_SEL_4;
    wr_ready <= 1'b0;
    for (k = 0; k < 12; k++) begin
      b = '{d_rise: 16'(16'h0101 * k), d_fall: 16'(16'hF0F0 ^ k), m_rise: 2'(k),
        m_fall: 2'(k >> 2)};
      host.beats.push_back(b);
      exp_q.push_back('{col: 11'(11'h040 + 2 * k), data: {b.d_fall, b.d_rise},
        mask: {b.m_fall, b.m_rise}});
    end
    for (k = 0; k < 6; k++) begin
      host.send(mk(OP_WR, 11'(11'h040 + 4 * k), 1'b0, 1'b0, 3'h0));
    end
    tick(10);
    chk(47'(ovr_seen), 47'h1, "overrun");
    for (k = 0; k < 9; k++) begin
      pop_word();
    end
    @(posedge core_clk) wr_ready <= 1'b1;
    tick(12);
    chk(47'(wr_valid), 47'h0, "drained");
    final_report();
  end
endmodule // tb
